/* File: bench/lcd_power_entry_mode_decode_bench.sv */
/*
  self-checking bench for the power and entry-mode decoder;
  assumes the host model drives all bus inputs.
*/
`timescale 1ns/1ns
module lcd_power_entry_mode_decode_bench
  import lpe_pkg::*;
;
  logic sys_clk;
  logic rst_n;
  logic bv, rs, rw, pg, av;
  logic [DATA_W-1:0] wd;
  logic [ADDR_W-1:0] av_val, addr;
  logic [1:0] boost;
  logic [2:0] bias;
  logic [4:0] den;
  logic [5:0] ct;
  logic inv, dir, hold;
  int n_mismatch = 0;
  int check_count = 0;
  int cyc = 0;
  lpe_host host_u (.sys_clk(sys_clk), .bus_valid(bv), .register_select_line(rs), .read_write_line(rw),
    .bus_wdata(wd), .instr_page_select(pg), .addr_set_valid(av), .addr_set_value(av_val));
  lpe_decode dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .bus_valid(bv), .register_select_line(rs),
    .read_write_line(rw), .bus_wdata(wd), .instr_page_select(pg), .addr_set_valid(av),
    .addr_set_value(av_val), .booster_factor(boost), .bias_select(bias), .bias_denom_x2(den),
    .contrast_setting(ct), .invert_display(inv), .addr_step_direction(dir),
    .read_hold_address(hold), .gram_addr(addr));
  task automatic stop_test();
    $display("mismatches %0d checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [10:0] got, input logic [10:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic t_power();
    logic [4:0] tab [8] = '{5'h14, 5'h13, 5'h12, 5'h10, 5'h0e, 5'h0c, 5'h0a, 5'h08};
    logic [1:0] b;
    for (int i = 0; i < 8; i++)
    begin
      b = 2'(i % 3);
      host_u.acc(1'b0, 1'b0, 1'b1, {3'h1, b, 3'(i)});
      #1;
      chk(11'(bias), 11'(i));
      chk(11'(den), 11'(tab[i]));
      chk(11'(boost), 11'(b));
    end
    // inhibited booster code: bias still taken, booster kept
    host_u.acc(1'b0, 1'b0, 1'b1, 8'h3d);
    #1;
    chk(11'(boost), 11'h001);
    chk(11'(bias), 11'h005);
    host_u.acc(1'b0, 1'b0, 1'b0, 8'h32);
    #1;
    chk(11'({boost, bias}), 11'h00d);
  endtask
  task automatic t_entry();
    host_u.acc(1'b0, 1'b0, 1'b0, 8'h05);
    #1;
    chk(11'({inv, dir}), 11'h002);
    host_u.acc(1'b1, 1'b0, 1'b0, 8'h00);
    #1;
    chk(addr, 11'h7ff);
    host_u.acc(1'b1, 1'b1, 1'b0, 8'h00);
    #1;
    chk(addr, 11'h7fe);
    host_u.acc(1'b0, 1'b0, 1'b0, 8'h03);
    host_u.acc(1'b0, 1'b0, 1'b0, 8'h06);
    #1;
    chk(11'({inv, dir}), 11'h001);
    host_u.acc(1'b0, 1'b0, 1'b1, 8'h07);
    #1;
    chk(11'({ct, hold, inv, dir}), 11'h105);
    host_u.acc(1'b0, 1'b0, 1'b1, 8'h5f);
    #1;
    chk(11'(ct), 11'h03f);
    host_u.rd2();
    #1;
    chk(addr, 11'h7fe);
    host_u.acc(1'b1, 1'b0, 1'b1, 8'ha5);
    #1;
    chk(addr, 11'h7ff);
    host_u.load(11'h123);
    host_u.acc(1'b0, 1'b0, 1'b1, 8'h01);
    host_u.acc(1'b1, 1'b1, 1'b1, 8'h00);
    #1;
    chk(11'(ct), 11'h01f);
    chk(addr, 11'h124);
    host_u.acc(1'b0, 1'b0, 1'b0, 8'h4a);
    #1;
    chk(11'(ct), 11'h00a);
  endtask
  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  // the whole run needs well under a thousand cycles
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      n_mismatch++;
      stop_test();
    end
  end
  initial
  begin
    rst_n = 1'b0;
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    #1;
    chk({boost, bias, den, inv}, 11'h028);
    chk(11'({ct, dir, hold}), 11'h002);
    chk(addr, 11'h000);
    t_power();
    t_entry();
    stop_test();
  end
endmodule

/* File: bench/lpe_host.sv */
/*
  host model: issues instruction, data and counter-load strobes to the decoder;
  assumes it shares sys_clk with the decoder.
*/
`timescale 1ns/1ns
module lpe_host
  import lpe_pkg::*;
(
  input wire logic sys_clk,
  output logic bus_valid,
  output logic register_select_line,
  output logic read_write_line,
  output logic [DATA_W-1:0] bus_wdata,
  output logic instr_page_select,
  output logic addr_set_valid,
  output logic [ADDR_W-1:0] addr_set_value
);
  initial
  begin
    {bus_valid, register_select_line, read_write_line, instr_page_select} = 4'h0;
    bus_wdata = 8'h00;
    addr_set_valid = 1'b0;
    addr_set_value = 11'h000;
  end
  // data is inverted after the strobe so a stale byte never looks valid
  task automatic acc(input logic rs, input logic rw, input logic pg, input logic [7:0] d);
    @(posedge sys_clk);
    {register_select_line, read_write_line, instr_page_select, bus_wdata} <= {rs, rw, pg, d};
    bus_valid <= 1'b1;
    @(posedge sys_clk);
    bus_valid <= 1'b0;
    bus_wdata <= ~d;
  endtask
  // first word back is stale, so rd2 does the read twice
  task automatic rd2();
    acc(1'b1, 1'b1, 1'b1, 8'h00);
    acc(1'b1, 1'b1, 1'b1, 8'h00);
  endtask
  task automatic load(input logic [ADDR_W-1:0] a);
    @(posedge sys_clk);
    addr_set_valid <= 1'b1;
    addr_set_value <= a;
    @(posedge sys_clk);
    addr_set_valid <= 1'b0;
    addr_set_value <= ~a;
  endtask
endmodule

/* File: core/lpe_addr_ctr.sv */
/*
  graphics RAM address counter: moves by one per step request, loads on
  request; assumes step and load are single-cycle strobes on sys_clk.
*/
`timescale 1ns/1ns
module lpe_addr_ctr
  import lpe_pkg::*;
#(
  parameter int AW = ADDR_W
)
(
  input wire logic sys_clk,
  input wire logic rst_n,
  lpe_step_if.ctr st
);
  typedef struct packed {
    logic [AW-1:0] addr;
  } lpe_ctr_s;

  lpe_ctr_s s_q;
  lpe_ctr_s s_d;

  always_comb
  begin
    s_d = s_q;
    // a load wins so software repositioning is never lost to a stray step
    if (st.load)
      s_d.addr = st.load_addr;
    else if (st.step && st.dir_up)
      s_d.addr = s_q.addr + AW'(1);
    else if (st.step)
      s_d.addr = s_q.addr - AW'(1);
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      s_q <= '{addr: AW'(ADDR_RST)};
    else
      s_q <= s_d;
  end

  assign st.addr = s_q.addr;
endmodule

/* File: core/lpe_decode.sv */
/*
  power and entry-mode instruction decoder with the graphics RAM address
  counter; assumes bus inputs are synchronous to sys_clk, one access per
  cycle with bus_valid high.
*/
// Operation
// - page one: booster_factor picks triple, quadruple or five-times; code 11 forbidden.
// - page one: bias_select codes 0..7 give 1/10,1/9.5,1/9,1/8,1/7,1/6,1/5,1/4.
// - page zero with invert_display set: whole graphics display black-white swapped.
// - every graphics_ram write, and every read with read_hold_address zero, without addr_set_valid, moves counter by one, up or down per direction.
// - page one entry-mode writes contrast_msb; with contrast_low_bits forms 64 steps.
// - read_hold_address one freezes the counter after reads; zero lets reads step it.
// - page zero entry mode: read_write_line low, bit2 invert, bit1 direction, bit0 one.
`timescale 1ns/1ns
module lpe_decode
  import lpe_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic bus_valid,
  input wire logic register_select_line,
  input wire logic read_write_line,
  input wire logic [DATA_W-1:0] bus_wdata,
  input wire logic instr_page_select,
  input wire logic addr_set_valid,
  input wire logic [ADDR_W-1:0] addr_set_value,
  output logic [1:0] booster_factor,
  output logic [2:0] bias_select,
  output logic [4:0] bias_denom_x2,
  output logic [5:0] contrast_setting,
  output logic invert_display,
  output logic addr_step_direction,
  output logic read_hold_address,
  output logic [ADDR_W-1:0] gram_addr
);
  typedef struct packed {
    logic [1:0] boost;
    logic [2:0] bias;
    logic [4:0] bias_x2;
    logic ct_msb;
    logic [4:0] ct_low;
    logic invert;
    logic dir_up;
    logic hold;
  } lpe_state_s;

  lpe_state_s s_q;
  lpe_state_s s_d;
  logic instr_wr;
  logic gram_wr;
  logic gram_rd;
  // the inhibited booster code is declared ahead of the decode that filters it
  localparam logic [1:0] BOOSTED_GUARD = BOOST_INHIBITED;

  lpe_step_if #(.AW(ADDR_W)) step_bus ();

  assign instr_wr = bus_valid && !register_select_line && !read_write_line;
  assign gram_wr = bus_valid && register_select_line && !read_write_line;
  assign gram_rd = bus_valid && register_select_line && read_write_line;

  always_comb
  begin
    s_d = s_q;
    if (instr_wr && lpe_is_entry(bus_wdata))
    begin
      if (instr_page_select)
      begin
        s_d.ct_msb = bus_wdata[CT_MSB_BIT];
        s_d.hold = bus_wdata[HOLD_BIT];
      end
      else
      begin
        s_d.invert = bus_wdata[INVERT_BIT];
        s_d.dir_up = bus_wdata[DIR_BIT];
      end
    end
    if (instr_wr && instr_page_select && lpe_is_power(bus_wdata))
    begin
      // an inhibited boost code is dropped so the pump never sees it
      if (bus_wdata[BOOST_LSB+:2] != BOOSTED_GUARD)
        s_d.boost = bus_wdata[BOOST_LSB+:2];
      s_d.bias = bus_wdata[BIAS_LSB+:3];
      s_d.bias_x2 = lpe_bias_x2(bus_wdata[BIAS_LSB+:3]);
    end
    if (instr_wr && lpe_is_contrast(bus_wdata))
      s_d.ct_low = bus_wdata[4:0];
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      s_q <= '{boost: BOOST_RST, bias: BIAS_RST, bias_x2: 5'h14, ct_msb: CT_MSB_RST,
               ct_low: CT_LOW_RST, invert: INVERT_RST, dir_up: DIR_RST, hold: HOLD_RST};
    else
      s_q <= s_d;
  end

  // reads under hold leave the counter for read-modify-write; first read data is stale
  assign step_bus.step = gram_wr || (gram_rd && !s_q.hold);
  assign step_bus.dir_up = s_q.dir_up;
  assign step_bus.load = addr_set_valid;
  assign step_bus.load_addr = addr_set_value;

  lpe_addr_ctr #(.AW(ADDR_W)) u_ctr (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .st(step_bus.ctr)
  );

  assign booster_factor = s_q.boost;
  assign bias_select = s_q.bias;
  assign bias_denom_x2 = s_q.bias_x2;
  assign contrast_setting = {s_q.ct_msb, s_q.ct_low};
  assign invert_display = s_q.invert;
  assign addr_step_direction = s_q.dir_up;
  assign read_hold_address = s_q.hold;
  assign gram_addr = step_bus.addr;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_power_wr;
    instr_wr && instr_page_select && lpe_is_power(bus_wdata);
  endsequence

  sequence s_entry0_wr;
    instr_wr && !instr_page_select && lpe_is_entry(bus_wdata);
  endsequence

  sequence s_entry1_wr;
    instr_wr && instr_page_select && lpe_is_entry(bus_wdata);
  endsequence

  property p_boost_set;
    s_power_wr ##0 (bus_wdata[4:3] != 2'h3) |=> booster_factor == $past(bus_wdata[4:3]);
  endproperty
  a_boost_set: assert property (p_boost_set) else $error("booster not taken");

  property p_boost_inhibit;
    s_power_wr ##0 (bus_wdata[4:3] == 2'h3) |=> $stable(booster_factor) && booster_factor != 2'h3;
  endproperty
  a_boost_inhibit: assert property (p_boost_inhibit) else $error("inhibited boost accepted");

  property p_bias_map;
    s_power_wr ##0 (bus_wdata[2:0] == 3'h1) |=> bias_select == 3'h1 && bias_denom_x2 == 5'h13;
  endproperty
  a_bias_map: assert property (p_bias_map) else $error("bias 1/9.5 mismapped");

  property p_invert;
    s_entry0_wr |=> invert_display == $past(bus_wdata[2]) && addr_step_direction == $past(bus_wdata[1]);
  endproperty
  a_invert: assert property (p_invert) else $error("entry page zero fields wrong");

  property p_step;
    gram_wr && !addr_set_valid |=> gram_addr == ($past(addr_step_direction) ?
      ADDR_W'($past(gram_addr) + 11'h001) : ADDR_W'($past(gram_addr) - 11'h001));
  endproperty
  a_step: assert property (p_step) else $error("counter did not step by one");

  property p_contrast;
    s_entry1_wr |=> contrast_setting[5] == $past(bus_wdata[2]) && $stable(invert_display);
  endproperty
  a_contrast: assert property (p_contrast) else $error("contrast msb not taken");

  property p_hold;
    gram_rd && read_hold_address && !addr_set_valid |=> $stable(gram_addr);
  endproperty
  a_hold: assert property (p_hold) else $error("counter moved on held read");

  property p_entry_mark;
    instr_wr && bus_wdata[7:3] == 5'h00 && !bus_wdata[0] |=> $stable(invert_display) && $stable(read_hold_address);
  endproperty
  a_entry_mark: assert property (p_entry_mark) else $error("entry taken with bit0 clear");

  property p_keep;
    !instr_wr [*2] |=> $stable(booster_factor) && $stable(bias_select) && $stable(contrast_setting);
  endproperty
  a_keep: assert property (p_keep) else $error("setting changed without write");

  sequence s_contrast_wr;
    instr_wr && lpe_is_contrast(bus_wdata);
  endsequence

  sequence s_power0_wr;
    instr_wr && !instr_page_select && lpe_is_power(bus_wdata);
  endsequence

  property p_boost_legal;
    booster_factor != 2'h3;
  endproperty
  a_boost_legal: assert property (p_boost_legal) else $error("booster holds inhibited code");

  property p_bias_take;
    s_power_wr |=> bias_select == $past(bus_wdata[2:0]);
  endproperty
  a_bias_take: assert property (p_bias_take) else $error("bias code not taken");

  property p_bias_end;
    s_power_wr ##0 (bus_wdata[2:0] == 3'h7) |=> bias_denom_x2 == 5'h08;
  endproperty
  a_bias_end: assert property (p_bias_end) else $error("bias 1/4 mismapped");

  property p_power0;
    s_power0_wr |=> $stable(booster_factor) && $stable(bias_select) && $stable(bias_denom_x2);
  endproperty
  a_power0: assert property (p_power0) else $error("power taken on page zero");

  property p_ct_low;
    s_contrast_wr |=> contrast_setting[4:0] == $past(bus_wdata[4:0]);
  endproperty
  a_ct_low: assert property (p_ct_low) else $error("contrast low bits not taken");

  property p_hold_set;
    s_entry1_wr |=> read_hold_address == $past(bus_wdata[1]) && $stable(addr_step_direction);
  endproperty
  a_hold_set: assert property (p_hold_set) else $error("read hold not taken");

  property p_read_step;
    gram_rd && !read_hold_address && !addr_set_valid |=> gram_addr == ($past(addr_step_direction) ?
      ADDR_W'($past(gram_addr) + 11'h001) : ADDR_W'($past(gram_addr) - 11'h001));
  endproperty
  a_read_step: assert property (p_read_step) else $error("counter did not step on read");

  property p_idle_addr;
    !gram_wr && !gram_rd && !addr_set_valid |=> $stable(gram_addr);
  endproperty
  a_idle_addr: assert property (p_idle_addr) else $error("counter moved without access");

  property p_load;
    addr_set_valid |=> gram_addr == $past(addr_set_value);
  endproperty
  a_load: assert property (p_load) else $error("counter load lost");
endmodule

/* File: pkg/lpe_pkg.sv */
/*
  shared constants, field layouts and instruction decoders for the power and
  entry-mode instruction decoder; assumes an 8-bit instruction/data bus.
*/
package lpe_pkg;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 11;
  // instruction opcodes sit in the high bits of the data byte
  localparam logic [4:0] ENTRY_OPC = 5'h00;
  localparam logic [2:0] POWER_OPC = 3'h1;
  localparam logic [2:0] CONTRAST_OPC = 3'h2;
  // entry-mode fields
  localparam int ENTRY_MARK_BIT = 0;
  localparam int INVERT_BIT = 2;
  localparam int DIR_BIT = 1;
  localparam int CT_MSB_BIT = 2;
  localparam int HOLD_BIT = 1;
  // power-control fields
  localparam int BOOST_LSB = 3;
  localparam int BIAS_LSB = 0;
  localparam logic [1:0] BOOST_INHIBITED = 2'h3;
  // reset values
  localparam logic [1:0] BOOST_RST = 2'h0;
  localparam logic [2:0] BIAS_RST = 3'h0;
  localparam logic [4:0] CT_LOW_RST = 5'h00;
  localparam logic CT_MSB_RST = 1'b0;
  localparam logic INVERT_RST = 1'b0;
  localparam logic DIR_RST = 1'b1;
  localparam logic HOLD_RST = 1'b0;
  localparam logic [ADDR_W-1:0] ADDR_RST = 11'h000;

  function automatic logic lpe_is_entry(input logic [DATA_W-1:0] d);
    lpe_is_entry = (d[7:3] == ENTRY_OPC) && d[ENTRY_MARK_BIT];
  endfunction

  function automatic logic lpe_is_power(input logic [DATA_W-1:0] d);
    lpe_is_power = (d[7:5] == POWER_OPC);
  endfunction

  function automatic logic lpe_is_contrast(input logic [DATA_W-1:0] d);
    lpe_is_contrast = (d[7:5] == CONTRAST_OPC);
  endfunction

  // bias denominator times two: 1/9.5 becomes 19
  function automatic logic [4:0] lpe_bias_x2(input logic [2:0] code);
    case (code)
      3'h0: lpe_bias_x2 = 5'h14;
      3'h1: lpe_bias_x2 = 5'h13;
      3'h2: lpe_bias_x2 = 5'h12;
      3'h3: lpe_bias_x2 = 5'h10;
      3'h4: lpe_bias_x2 = 5'h0e;
      3'h5: lpe_bias_x2 = 5'h0c;
      3'h6: lpe_bias_x2 = 5'h0a;
      default: lpe_bias_x2 = 5'h08;
    endcase
  endfunction
endpackage

/* File: pkg/lpe_step_if.sv */
/*
  carries address-counter step and load requests from the decoder to the
  counter; both ends share sys_clk.
*/
`timescale 1ns/1ns
interface lpe_step_if #(parameter int AW = 11);
  logic step;
  logic dir_up;
  logic load;
  logic [AW-1:0] load_addr;
  logic [AW-1:0] addr;
  modport ctl (output step, output dir_up, output load, output load_addr, input addr);
  modport ctr (input step, input dir_up, input load, input load_addr, output addr);
endinterface
